// ==== design/eicl_pkg.sv ====
// shared constants and carrier types of the configuration image loader
package eicl_pkg;

  // image layout, byte addresses
  localparam logic [6:0] A_SIG        = 7'h00;
  localparam logic [6:0] A_FLAGS0     = 7'h04;
  localparam logic [6:0] A_FLAGS0_END = 7'h07;
  localparam logic [6:0] A_PIN_FIRST  = 7'h20;
  localparam logic [6:0] A_PIN_LAST   = 7'h2f;
  localparam logic [6:0] A_DESC_FIRST = 7'h32;
  localparam logic [6:0] A_DESC_LAST  = 7'h49;
  localparam logic [7:0] SIGNATURE    = 8'ha5;
  localparam int         NUM_DESC     = 12;
  localparam int         IMG_ADDR_W   = 9;

  // configuration flags word 0 field positions
  localparam int F_PWR     = 0;
  localparam int F_BOOST   = 1;
  localparam int F_LPM     = 3;
  localparam int F_SQU     = 4;
  localparam int F_EXTRST  = 6;
  localparam int F_IRQ     = 7;
  localparam int F_IND_ON  = 8;
  localparam int F_IND_POL = 9;
  localparam int F_IND_BUF = 10;
  localparam int F_SWM     = 11;
  localparam int F_SWAP    = 12;
  localparam int F_XTAL    = 13;
  localparam logic [31:0] FLAGS0_MASK = 32'h0000_3fff;
  localparam logic [31:0] FLAGS0_RST  = 32'h0000_0008;
  localparam logic [31:0] PIN_RST     = 32'h0000_0000;

  // register map, byte offsets
  localparam logic [11:0] R_CTRL    = 12'h000;
  localparam logic [11:0] R_STATUS  = 12'h004;
  localparam logic [11:0] R_PIN_EN  = 12'h008;
  localparam logic [11:0] R_PIN_BUF = 12'h00c;
  localparam logic [11:0] R_PIN_DIR = 12'h010;
  localparam logic [11:0] R_PIN_VAL = 12'h014;
  localparam logic [11:0] R_FLAGS0  = 12'h018;
  localparam logic [11:0] R_DESC    = 12'h040;
  localparam int CTRL_RELOAD = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_LOADED   = 1;
  localparam int ST_NOIMG    = 2;
  localparam int ST_TMO      = 3;

  // byte fetch timeout
  localparam int CLK_MHZ          = 10;
  localparam int FETCH_TIMEOUT_US = 100;
  localparam int FETCH_TIMEOUT_CYC = FETCH_TIMEOUT_US * CLK_MHZ;

  typedef struct packed {
    logic       power_method_select;
    logic [1:0] phy_drive_boost;
    logic       link_power_mgmt_on;
    logic [1:0] squelch_level;
    logic       ext_reset_polarity;
    logic       irq_pin_polarity;
    logic       indicator_on;
    logic       indicator_polarity;
    logic       indicator_buffer_kind;
    logic       switch_mode_polarity;
    logic       dataline_swap;
    logic       crystal_keepalive;
  } eicl_cfg_s;

  // entries: mfr, product, serial, config str, iface str, bos,
  // ss dev, ss cfg, hs dev, hs cfg, fs dev, fs cfg
  typedef struct packed {
    logic       present;
    logic [7:0] len;
    logic [7:0] word_off;
    logic [8:0] byte_addr;
  } eicl_desc_s;

  function automatic eicl_cfg_s flags_to_cfg(input logic [31:0] f);
    eicl_cfg_s c;
    c.power_method_select   = f[F_PWR];
    c.phy_drive_boost       = f[F_BOOST+:2];
    c.link_power_mgmt_on    = f[F_LPM];
    c.squelch_level         = f[F_SQU+:2];
    c.ext_reset_polarity    = f[F_EXTRST];
    c.irq_pin_polarity      = f[F_IRQ];
    c.indicator_on          = f[F_IND_ON];
    c.indicator_polarity    = f[F_IND_POL];
    c.indicator_buffer_kind = f[F_IND_BUF];
    c.switch_mode_polarity  = f[F_SWM];
    c.dataline_swap         = f[F_SWAP];
    c.crystal_keepalive     = f[F_XTAL];
    return c;
  endfunction : flags_to_cfg

endpackage : eicl_pkg

// ==== design/eicl_fetch.sv ====
// single byte fetch from the image store with timeout
`timescale 1ns/1ps
module eicl_fetch import eicl_pkg::*; #(
  parameter int TIMEOUT_CYC = FETCH_TIMEOUT_CYC,
  parameter int ADDR_W      = IMG_ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              go,
  input  wire logic [6:0]        addr,
  input  wire logic              ee_ack,
  input  wire logic [7:0]        ee_data,
  output logic                   ee_req,
  output logic [ADDR_W-1:0]      ee_addr,
  output logic                   done,
  output logic                   tmo,
  output logic [7:0]             data
);
  generate
    if (ADDR_W < 7 || TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_bad
      $error("eicl_fetch: unsupported parameter values");
    end
  endgenerate

  localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_CYC - 1);

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       cnt;
    logic              done;
    logic              tmo;
    logic [7:0]        data;
  } eicl_fetch_state_s;

  eicl_fetch_state_s s_reg;
  eicl_fetch_state_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (go) begin
      s_next.req  = 1'b1;
      s_next.addr = ADDR_W'(addr);
      s_next.cnt  = 16'h0000;
      s_next.tmo  = 1'b0;
    end else if (s_reg.req) begin
      if (ee_ack) begin
        s_next.req  = 1'b0;
        s_next.data = ee_data;
        s_next.done = 1'b1;
      end else if (s_reg.cnt == TMO_LAST) begin
        // an absent store must not hang the load forever
        s_next.req  = 1'b0;
        s_next.done = 1'b1;
        s_next.tmo  = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ee_req  = s_reg.req;
  assign ee_addr = s_reg.addr;
  assign done    = s_reg.done;
  assign tmo     = s_reg.tmo;
  assign data    = s_reg.data;
endmodule : eicl_fetch

// ==== design/eicl_ahb.sv ====
// ahb-lite slave front end: write strobe and one-wait-state reads
`timescale 1ns/1ps
module eicl_ahb import eicl_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] rdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output logic [11:0]      reg_addr
);
  typedef struct packed {
    logic        ready;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] rdata;
  } eicl_ahb_state_s;

  eicl_ahb_state_s s_reg;
  eicl_ahb_state_s s_next;
  logic            accept;

  always_comb begin
    accept   = hsel && htrans[1] && hready;
    s_next    = s_reg;
    s_next.wr = 1'b0;
    if (!s_reg.ready) begin
      s_next.rdata = rdata;
      s_next.ready = 1'b1;
    end
    if (accept) begin
      s_next.addr = haddr[11:0];
      // narrow writes are dropped, bus only carries whole words
      s_next.wr   = hwrite && (hsize == 3'h2);
      if (!hwrite) begin
        s_next.ready = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_reg       <= '0;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.ready;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;
  assign wr_en     = s_reg.wr;
  assign reg_addr  = s_reg.addr;
endmodule : eicl_ahb

// ==== design/eicl_loader.sv ====
// configuration image loader top: fetch, stage, commit, register access
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module eicl_loader import eicl_pkg::*; #(
  parameter int TIMEOUT_CYC = FETCH_TIMEOUT_CYC
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  // register bus
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // image store
  input  wire logic             ee_ack,
  input  wire logic [7:0]       ee_data,
  output logic                  ee_req,
  output logic [IMG_ADDR_W-1:0] ee_addr,
  // loaded values
  output logic [31:0]           pin_enable,
  output logic [31:0]           pin_buffer,
  output logic [31:0]           pin_direction,
  output logic [31:0]           pin_value,
  output eicl_cfg_s             usb_cfg,
  output eicl_desc_s [NUM_DESC-1:0] desc_table,
  // load status
  output logic                  load_busy,
  output logic                  image_loaded
);
  typedef enum logic [1:0] {
    LD_IDLE   = 2'b00,
    LD_SIG    = 2'b01,
    LD_BODY   = 2'b10,
    LD_COMMIT = 2'b11
  } eicl_ld_e;

  // whole loader state, registered in one place
  typedef struct packed {
    // sequencing
    eicl_ld_e                      st;
    logic                          start;
    logic                          go;
    logic [6:0]                    cur;
    // staging, filled as bytes arrive
    logic [3:0][31:0]              stage_pin;
    logic [31:0]                   stage_flags;
    logic [NUM_DESC-1:0][15:0]     stage_desc;
    // committed values
    logic [3:0][31:0]              pin;
    logic [31:0]                   flags;
    eicl_cfg_s                     cfg;
    eicl_desc_s [NUM_DESC-1:0]     desc;
    // status flags
    logic                          busy;
    logic                          loaded;
    logic                          noimg;
    logic                          tmo;
  } eicl_state_s;

  eicl_state_s s_reg;
  eicl_state_s s_next;

  // fetch counter is 16 bits; the table must span the fixed entry bytes
  generate
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_bad_timeout
      $error("eicl_loader: timeout does not fit the fetch counter");
    end
    if (NUM_DESC * 2 != int'(A_DESC_LAST - A_DESC_FIRST) + 1) begin : g_bad_table
      $error("eicl_loader: table size does not match the entry bytes");
    end
  endgenerate

  logic        f_done;
  logic        f_tmo;
  logic [7:0]  f_data;
  logic        wr_en;
  logic [11:0] reg_addr;
  logic [31:0] rdata;

  // walk only the fixed fields; gaps and the free area are skipped
  function automatic logic [6:0] next_addr(input logic [6:0] a);
    logic [6:0] n;
    n = a + 7'h01;
    if (a == A_SIG) begin
      n = A_FLAGS0;
    end else if (a == A_FLAGS0_END) begin
      n = A_PIN_FIRST;
    end else if (a == A_PIN_LAST) begin
      n = A_DESC_FIRST;
    end
    return n;
  endfunction : next_addr

  // pin word index for a register offset, 4 when not a pin register
  function automatic logic [2:0] pin_index(input logic [11:0] a);
    logic [2:0] i;
    i = 3'h4;
    if (a == R_PIN_EN) begin
      i = 3'h0;
    end else if (a == R_PIN_BUF) begin
      i = 3'h1;
    end else if (a == R_PIN_DIR) begin
      i = 3'h2;
    end else if (a == R_PIN_VAL) begin
      i = 3'h3;
    end
    return i;
  endfunction : pin_index

  // status register word
  function automatic logic [31:0] status_word(input eicl_state_s s);
    logic [31:0] w;
    w            = 32'h0000_0000;
    w[ST_BUSY]   = s.busy;
    w[ST_LOADED] = s.loaded;
    w[ST_NOIMG]  = s.noimg;
    w[ST_TMO]    = s.tmo;
    return w;
  endfunction : status_word

  // one table entry from its stored length and word offset pair
  function automatic eicl_desc_s desc_entry(input logic [15:0] pair);
    eicl_desc_s e;
    e.len       = pair[7:0];
    e.word_off  = pair[15:8];
    e.present   = pair[7:0] != 8'h00;
    // table keeps a byte address beside the word offset
    e.byte_addr = {pair[15:8], 1'b0};
    return e;
  endfunction : desc_entry

  // one byte at a time; the timeout lives in the fetch unit
  eicl_fetch #(
    .TIMEOUT_CYC (TIMEOUT_CYC),
    .ADDR_W      (IMG_ADDR_W)
  ) u_fetch (
    .mclk    (mclk),
    .resetn  (resetn),
    .go      (s_reg.go),
    .addr    (s_reg.cur),
    .ee_ack  (ee_ack),
    .ee_data (ee_data),
    .ee_req  (ee_req),
    .ee_addr (ee_addr),
    .done    (f_done),
    .tmo     (f_tmo),
    .data    (f_data)
  );

  // reads answer after one wait state
  eicl_ahb u_ahb (
    .mclk      (mclk),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rdata     (rdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .reg_addr  (reg_addr)
  );

  // read mux, addressed by the held data-phase address
  always_comb begin
    logic [2:0] pi;
    logic [3:0] di;

    pi    = pin_index(reg_addr);
    di    = reg_addr[5:2];
    rdata = 32'h0000_0000;
    if (pi != 3'h4) begin
      rdata = s_reg.pin[pi[1:0]];
    end else if (reg_addr == R_STATUS) begin
      rdata = status_word(s_reg);
    end else if (reg_addr == R_FLAGS0) begin
      rdata = s_reg.flags;
    end else if (reg_addr[11:6] == R_DESC[11:6] && reg_addr[1:0] == 2'b00
                 && di < 4'(NUM_DESC)) begin
      rdata = {6'h00, s_reg.desc[di]};
    end
  end

  // load sequencer and software side
  always_comb begin
    logic [1:0] lane;
    logic [3:0] di;
    logic [2:0] pi;

    lane         = s_reg.cur[1:0];
    di           = 4'((s_reg.cur - A_DESC_FIRST) >> 1);
    pi           = pin_index(reg_addr);
    s_next       = s_reg;
    s_next.go    = 1'b0;

    // software pin word overrides; a commit in the same cycle wins
    if (wr_en && pi != 3'h4) begin
      s_next.pin[pi[1:0]] = hwdata;
    end

    unique case (s_reg.st)
      LD_IDLE: begin
        if (s_reg.start) begin
          s_next.start  = 1'b0;
          s_next.st     = LD_SIG;
          s_next.cur    = A_SIG;
          s_next.go     = 1'b1;
          s_next.busy   = 1'b1;
          s_next.loaded = 1'b0;
          s_next.noimg  = 1'b0;
          s_next.tmo    = 1'b0;
        end
      end

      LD_SIG: begin
        // first byte decides whether an image is there at all
        if (f_done) begin
          if (f_tmo) begin
            // no answer at all: outputs keep their values
            s_next.tmo  = 1'b1;
            s_next.busy = 1'b0;
            s_next.st   = LD_IDLE;
          end else if (f_data != SIGNATURE) begin
            // no image: registers keep what they hold
            s_next.noimg = 1'b1;
            s_next.busy  = 1'b0;
            s_next.st    = LD_IDLE;
          end else begin
            s_next.cur = next_addr(s_reg.cur);
            s_next.go  = 1'b1;
            s_next.st  = LD_BODY;
          end
        end
      end

      LD_BODY: begin
        if (f_done) begin
          if (f_tmo) begin
            // partial image is discarded, nothing reaches the outputs
            s_next.tmo  = 1'b1;
            s_next.busy = 1'b0;
            s_next.st   = LD_IDLE;
          end else begin
            if (s_reg.cur <= A_FLAGS0_END) begin
              s_next.stage_flags[{lane, 3'b000}+:8] = f_data;
            end else if (s_reg.cur <= A_PIN_LAST) begin
              s_next.stage_pin[s_reg.cur[3:2]][{lane, 3'b000}+:8] = f_data;
            end else begin
              // even byte length, odd byte word offset
              s_next.stage_desc[di][{s_reg.cur[0], 3'b000}+:8] = f_data;
            end

            // bytes come in address order, so the last entry byte ends the walk
            if (s_reg.cur == A_DESC_LAST) begin
              s_next.st = LD_COMMIT;
            end else begin
              s_next.cur = next_addr(s_reg.cur);
              s_next.go  = 1'b1;
            end
          end
        end
      end

      LD_COMMIT: begin
        // all lands on one edge, so no reader sees a mixed set
        s_next.pin    = s_reg.stage_pin;
        s_next.flags  = s_reg.stage_flags & FLAGS0_MASK;
        s_next.cfg    = flags_to_cfg(s_reg.stage_flags);
        for (int i = 0; i < NUM_DESC; i++) begin
          s_next.desc[i] = desc_entry(s_reg.stage_desc[i]);
        end

        s_next.loaded = 1'b1;
        s_next.busy   = 1'b0;
        s_next.st     = LD_IDLE;
      end
    endcase

    // a reload request wins over the clear in the same cycle
    if (wr_en && reg_addr == R_CTRL && hwdata[CTRL_RELOAD]) begin
      s_next.start = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // reset values stand until an image commits or software writes a pin word
      s_reg       <= '0;
      s_reg.st    <= LD_IDLE;
      // every chip reset triggers a load
      s_reg.start <= 1'b1;
      s_reg.pin   <= {PIN_RST, PIN_RST, PIN_RST, PIN_RST};
      s_reg.flags <= FLAGS0_RST & FLAGS0_MASK;
      s_reg.cfg   <= flags_to_cfg(FLAGS0_RST);
    end else begin
      s_reg <= s_next;
    end
  end

  // every loaded value and status output is a register field; hresp is tied low in eicl_ahb
  assign pin_enable    = s_reg.pin[0];
  assign pin_buffer    = s_reg.pin[1];
  assign pin_direction = s_reg.pin[2];
  assign pin_value     = s_reg.pin[3];

  assign usb_cfg       = s_reg.cfg;
  assign desc_table    = s_reg.desc;
  assign load_busy     = s_reg.busy;
  assign image_loaded  = s_reg.loaded;
endmodule : eicl_loader

// ==== sim/eicl_ee_model.sv ====
// image store model answering byte fetches after a random delay
`timescale 1ns/1ps
module eicl_ee_model (
  input  wire logic       mclk,
  input  wire logic       ee_req,
  input  wire logic [8:0] ee_addr,
  input  wire logic       mute,
  output logic            ee_ack,
  output logic [7:0]      ee_data
);
  logic [7:0] mem [512];
  logic [2:0] wait_cnt;
  logic       served;
  initial begin
    {ee_ack, ee_data, wait_cnt, served} = '0;
  end
  always @(posedge mclk) begin
    ee_ack <= 1'b0;
    // never leave the last byte standing between answers
    ee_data <= ~ee_data;
    if (!ee_req) begin
      served <= 1'b0;
    end else if (!served && !mute) begin
      if (wait_cnt == 3'h0) begin
        ee_ack <= 1'b1;
        ee_data <= mem[ee_addr];
        served <= 1'b1;
        wait_cnt <= 3'($urandom_range(3));
      end else begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule : eicl_ee_model

// ==== sim/eicl_loader_checker.sv ====
// port assertions for the configuration image loader
`timescale 1ns/1ps
module eicl_loader_checker import eicl_pkg::*; #(
  parameter int TIMEOUT_CYC = FETCH_TIMEOUT_CYC
) (
  input wire logic                      mclk,
  input wire logic                      resetn,
  input wire logic                      hsel,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire logic                      ee_ack,
  input wire logic [7:0]                ee_data,
  input wire logic                      ee_req,
  input wire logic [IMG_ADDR_W-1:0]     ee_addr,
  input wire eicl_cfg_s                 usb_cfg,
  input wire eicl_desc_s [NUM_DESC-1:0] desc_table,
  input wire logic                      load_busy,
  input wire logic                      image_loaded
);
  logic        desc_ok;
  int unsigned wait_cyc;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  always_comb begin
    desc_ok = 1'b1;
    for (int i = 0; i < NUM_DESC; i++) begin
      desc_ok = desc_ok && (desc_table[i].byte_addr == {desc_table[i].word_off, 1'b0})
        && (desc_table[i].present == (desc_table[i].len != 8'h00));
    end
  end
  // unanswered fetch age, bounded by the timeout
  always_ff @(posedge mclk) begin
    if (!resetn || !ee_req || ee_ack) begin
      wait_cyc <= 0;
    end else begin
      wait_cyc <= wait_cyc + 1;
    end
  end
  property p_pins_after_flags;
    ee_req && ee_ack && ee_addr == 9'h007 |-> ##[1:4] (ee_req && ee_addr == 9'h020);
  endproperty
  a_pins_after_flags: assert property (p_pins_after_flags)
    else $error("pin bytes do not follow flags word");
  property p_desc_after_pins;
    ee_req && ee_ack && ee_addr == 9'h02f |-> ##[1:4] (ee_req && ee_addr == 9'h032);
  endproperty
  a_desc_after_pins: assert property (p_desc_after_pins)
    else $error("descriptor bytes do not follow pin bytes");
  property p_addr_range;
    $rose(ee_req) |-> ee_addr < 9'h04a && !(ee_addr inside {9'h030, 9'h031});
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("fetch outside the interpreted fields");
  property p_no_signature;
    ee_req && ee_ack && ee_addr == 9'h000 && ee_data != SIGNATURE
      |-> ##[1:4] (!load_busy && !ee_req && !image_loaded);
  endproperty
  a_no_signature: assert property (p_no_signature)
    else $error("load went on without signature");
  property p_cfg_commit;
    $changed(usb_cfg) |-> $rose(image_loaded);
  endproperty
  a_cfg_commit: assert property (p_cfg_commit)
    else $error("flag fields changed outside commit");
  property p_desc_commit;
    $changed(desc_table) |-> $rose(image_loaded);
  endproperty
  a_desc_commit: assert property (p_desc_commit)
    else $error("descriptor table changed outside commit");
  property p_desc_fields;
    desc_ok;
  endproperty
  a_desc_fields: assert property (p_desc_fields)
    else $error("descriptor presence or byte address wrong");
  property p_fetch_busy;
    ee_req |-> load_busy;
  endproperty
  a_fetch_busy: assert property (p_fetch_busy)
    else $error("fetch outside a load");
  property p_fetch_bound;
    wait_cyc <= TIMEOUT_CYC + 2;
  endproperty
  a_fetch_bound: assert property (p_fetch_bound)
    else $error("fetch waited past the timeout");
  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout ##0 !hresp;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read not one wait state or not okay");
endmodule : eicl_loader_checker
bind eicl_loader eicl_loader_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .mclk(mclk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ee_ack(ee_ack),
  .ee_data(ee_data), .ee_req(ee_req), .ee_addr(ee_addr), .usb_cfg(usb_cfg),
  .desc_table(desc_table), .load_busy(load_busy), .image_loaded(image_loaded)
);

// ==== sim/testbench.sv ====
// self-checking bench: image loads, refused loads, register access
`timescale 1ns/1ps
module testbench import eicl_pkg::*;;
  localparam int TMO = 8;
  logic                      mclk, resetn, hsel, hwrite, hreadyout, hresp, ee_ack, ee_req;
  logic                      load_busy, image_loaded, mute, rd_pend;
  logic [1:0]                htrans;
  logic [2:0]                hsize;
  logic [7:0]                ee_data;
  logic [8:0]                ee_addr;
  logic [31:0]               haddr, hwdata, hrdata, d;
  logic [31:0]               pin_enable, pin_buffer, pin_direction, pin_value;
  eicl_cfg_s                 usb_cfg;
  eicl_desc_s [NUM_DESC-1:0] desc_table;
  logic [31:0]               exp_q[$];
  string                     name_q[$];
  int                        bad_count, n_tests, cyc;

  eicl_loader #(.TIMEOUT_CYC(TMO)) i_dut (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ee_ack(ee_ack),
    .ee_data(ee_data), .ee_req(ee_req), .ee_addr(ee_addr), .pin_enable(pin_enable),
    .pin_buffer(pin_buffer), .pin_direction(pin_direction), .pin_value(pin_value),
    .usb_cfg(usb_cfg), .desc_table(desc_table), .load_busy(load_busy),
    .image_loaded(image_loaded)
  );
  eicl_ee_model i_ee (
    .mclk(mclk), .ee_req(ee_req), .ee_addr(ee_addr), .mute(mute), .ee_ack(ee_ack),
    .ee_data(ee_data)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  // read results are matched against the oldest note
  always @(posedge mclk) begin
    if (rd_pend && hreadyout) begin
      rd_pend <= 1'b0;
      cmp(name_q.pop_front(), exp_q.pop_front(), hrdata);
    end
  end

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] v,
                     input logic [2:0] sz);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    rd_pend <= !wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask : ahb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    exp_q.push_back(exp);
    name_q.push_back(nm);
    ahb(1'b0, a, 32'h0, 3'h2);
  endtask : rd

  task automatic wait_idle();
    repeat (3) @(posedge mclk);
    while (load_busy !== 1'b0) @(posedge mclk);
  endtask : wait_idle

  function automatic logic [31:0] word(input int a);
    return {i_ee.mem[a+3], i_ee.mem[a+2], i_ee.mem[a+1], i_ee.mem[a]};
  endfunction : word

  task automatic fill_img();
    for (int i = 0; i < 512; i++) i_ee.mem[i] = 8'($urandom);
    i_ee.mem[0] = SIGNATURE;
    // two absent items among the random lengths
    i_ee.mem[8'h36] = 8'h00;
    i_ee.mem[8'h44] = 8'h00;
  endtask : fill_img

  task automatic check_all();
    logic [31:0] f;
    logic [7:0]  ln, of;
    f = word(4);
    cmp("pin_enable", word(8'h20), pin_enable);
    cmp("pin_buffer", word(8'h24), pin_buffer);
    cmp("pin_direction", word(8'h28), pin_direction);
    cmp("pin_value", word(8'h2c), pin_value);
    cmp("usb_cfg", {18'h0, f[0], f[2:1], f[3], f[5:4], f[6], f[7], f[8], f[9], f[10],
        f[11], f[12], f[13]}, {18'h0, usb_cfg});
    for (int i = 0; i < NUM_DESC; i++) begin
      ln = i_ee.mem[8'h32+2*i];
      of = i_ee.mem[8'h33+2*i];
      cmp("desc_table", {6'h0, ln != 8'h0, ln, of, of, 1'b0}, {6'h0, desc_table[i]});
    end
    rd(R_FLAGS0, {18'h0, f[13:0]}, "flags0 register");
    rd(R_PIN_DIR, word(8'h28), "pin_direction register");
    rd(12'h06c, {6'h0, ln != 8'h0, ln, of, of, 1'b0}, "last entry register");
  endtask : check_all

  task automatic reload(input string nm, input logic [31:0] st);
    ahb(1'b1, R_CTRL, 32'h1, 3'h2);
    wait_idle();
    i_ee.mem[0] = SIGNATURE;
    mute <= 1'b0;
    rd(R_STATUS, st, "status");
    cmp("image_loaded", {31'h0, st[1]}, {31'h0, image_loaded});
    cmp("load_busy", 32'h0, {31'h0, load_busy});
    check_all();
    $display("%s done", nm);
  endtask : reload

  initial begin
    {hsel, htrans, haddr, hwrite, hwdata, mute, rd_pend, resetn, d} = '0;
    hsize = 3'h2;
    void'($urandom(32'hb23b58ac));
    fill_img();
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    wait_idle();
    rd(R_STATUS, 32'h2, "status");
    check_all();
    $display("power-up load done");
    i_ee.mem[0] = 8'h5a;
    reload("missing signature", 32'h4);
    mute <= 1'b1;
    reload("silent image store", 32'h8);
    fill_img();
    reload("second image", 32'h2);
    d = $urandom;
    ahb(1'b1, R_PIN_VAL, d, 3'h2);
    ahb(1'b1, R_PIN_VAL, ~d, 3'h0);
    ahb(1'b1, 12'h100, d, 3'h2);
    rd(R_PIN_VAL, d, "pin_value register");
    rd(12'h100, 32'h0, "unmapped read");
    cmp("pin_value port", d, pin_value);
    $display("register access done");
    @(posedge mclk);
    final_report();
  end
endmodule : testbench
